// ---- src/thc_defines.svh ----
`ifndef THC_DEFINES_SVH
`define THC_DEFINES_SVH

// evaluation cycle timing
`define THC_CLK_HZ 25000000
`define THC_SCAN_MS 10
`define THC_SCAN_CYCLES ((`THC_SCAN_MS * `THC_CLK_HZ) / 1000)
`define THC_SYNC_MS 500
`define THC_SYNC_SCANS (`THC_SYNC_MS / `THC_SCAN_MS)
`define THC_DISC_MAX_MS 500
`define THC_DISC_MAX (`THC_DISC_MAX_MS / `THC_SCAN_MS)
`define THC_DISC_DEF_MS 30
`define THC_DISC_DEF (`THC_DISC_DEF_MS / `THC_SCAN_MS)

// register byte offsets
`define THC_REG_CTRL 8'h00
`define THC_REG_DISC 8'h04
`define THC_REG_STAT 8'h08
`define THC_REG_IRQ_STAT 8'h0c
`define THC_REG_IRQ_EN 8'h10
`define THC_REG_IRQ_CLR 8'h14

// control fields
`define THC_CTRL_RUN 0
`define THC_CTRL_DISC1_OE 1
`define THC_CTRL_DISC2_OE 2
`define THC_CTRL_FAULT_OE 3
`define THC_CTRL_RESET 4'h0

// discrepancy time fields, in scans
`define THC_DISC1_LSB 0
`define THC_DISC2_LSB 8
`define THC_DISC_W 6

// event bits shared by irq status, enable and clear
`define THC_EV_DISC1 0
`define THC_EV_DISC2 1
`define THC_EV_SYNC 2
`define THC_EV_ENABLE 3
`define THC_EV_W 4

`endif

// ---- src/thc_pkg.sv ----
package thc_pkg;
   // hand synchronisation states
   typedef enum logic [3:0] {
      THC_READY = 4'b0001,
      THC_ARM = 4'b0010,
      THC_ENABLE = 4'b0100,
      THC_BLOCK = 4'b1000
   } thc_state_t;
endpackage : thc_pkg

// ---- src/thc_pair.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "thc_defines.svh"
module thc_pair
   import thc_pkg::*;
#(
   parameter int DW = `THC_DISC_W
)
(
   input wire logic clk, // system clock
   input wire logic rst_n, // synced reset
   input wire logic scan, // evaluation tick
   input wire logic no_in, // open-type contact
   input wire logic nc_in, // closed-type contact
   input wire logic [DW-1:0] limit, // time in scans
   input wire logic clr, // error clear pulse
   output logic err // latched error
);
   logic [DW-1:0] cnt;
   logic mismatch;

   assign mismatch = (no_in == nc_in);

   // mismatch duration in scans, saturating at the limit
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt <= '0;
      else if (scan)
      begin
         if (!mismatch)
            cnt <= '0;
         else if (cnt != limit)
            cnt <= cnt + 1'b1;
      end
   end

   // latched flag; a new detection beats a same-cycle clear
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         err <= 1'b0;
      else if (scan && mismatch && limit != '0 && cnt == limit)
         err <= 1'b1;
      else if (clr)
         err <= 1'b0;
   end
endmodule : thc_pair
`default_nettype wire

// ---- src/thc_top.sv ----
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "thc_defines.svh"
module thc_top
   import thc_pkg::*;
#(
   parameter int SCAN_CYCLES = `THC_SCAN_CYCLES,
   parameter int SYNC_SCANS = `THC_SYNC_SCANS,
   parameter int DW = `THC_DISC_W
)
(
   input wire logic ref_clk, // 25 MHz clock
   input wire logic rstn, // async reset, low
   input wire logic hsel, // ahb select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic hreadyout, // ahb slave ready
   output logic [31:0] hrdata, // ahb read data
   output logic hresp, // ahb response
   input wire logic p1_no, // pair 1 open-type contact
   input wire logic p1_nc, // pair 1 closed-type contact
   input wire logic p2_no, // pair 2 open-type contact
   input wire logic p2_nc, // pair 2 closed-type contact
   output logic out_enable, // safety output enable
   output logic disc_err1, // pair 1 error output
   output logic disc_err2, // pair 2 error output
   output logic fault_present, // shared fault
   output logic irq // level interrupt
);

   ////////////////////////////////////////////////////////////////////
   // reset release
   logic rst_ff1;
   logic rst_n;

   // two stages so release is clean against ref_clk
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_ff1 <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_ff1 <= 1'b1;
         rst_n <= rst_ff1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // evaluation cycle time base
   logic [31:0] scan_cnt;
   logic scan;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scan_cnt <= '0;
         scan <= 1'b0;
      end
      else if (scan_cnt == 32'(SCAN_CYCLES - 1))
      begin
         scan_cnt <= '0;
         scan <= 1'b1;
      end
      else
      begin
         scan_cnt <= scan_cnt + 32'h1;
         scan <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers
   logic [3:0] ctrl;
   logic [DW-1:0] disc1_time;
   logic [DW-1:0] disc2_time;
   logic [`THC_EV_W-1:0] irq_stat;
   logic [`THC_EV_W-1:0] irq_en;
   logic [`THC_EV_W-1:0] irq_clr;
   logic [`THC_EV_W-1:0] events;
   logic run;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic addr_ok;
   logic wr_do;
   logic [31:0] next_rdata;
   logic [DW-1:0] wr_d1;
   logic [DW-1:0] wr_d2;
   logic err1;
   logic err2;
   logic sync_fail;
   logic en_int;

   assign run = ctrl[`THC_CTRL_RUN];
   assign addr_ok = hsel && hready && htrans[1];
   assign wr_do = wr_pend;

   // capture write address phase; data follows next cycle
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else
      begin
         wr_pend <= addr_ok && hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   // zero-wait slave, always okay
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // clamp discrepancy times to the 500 ms ceiling
   always_comb
   begin
      wr_d1 = hwdata[`THC_DISC1_LSB +: DW];
      wr_d2 = hwdata[`THC_DISC2_LSB +: DW];
      if (wr_d1 > DW'(`THC_DISC_MAX))
         wr_d1 = DW'(`THC_DISC_MAX);
      if (wr_d2 > DW'(`THC_DISC_MAX))
         wr_d2 = DW'(`THC_DISC_MAX);
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl <= `THC_CTRL_RESET;
         disc1_time <= DW'(`THC_DISC_DEF);
         disc2_time <= DW'(`THC_DISC_DEF);
         irq_en <= '0;
      end
      else if (wr_do)
      begin
         if (wr_addr == `THC_REG_CTRL)
            ctrl <= hwdata[3:0];
         if (wr_addr == `THC_REG_DISC)
         begin
            disc1_time <= wr_d1;
            disc2_time <= wr_d2;
         end
         if (wr_addr == `THC_REG_IRQ_EN)
            irq_en <= hwdata[`THC_EV_W-1:0];
      end
   end

   // write-one-to-clear mask, only in the data phase
   always_comb
   begin
      irq_clr = '0;
      if (wr_do && wr_addr == `THC_REG_IRQ_CLR)
         irq_clr = hwdata[`THC_EV_W-1:0];
   end

   // read mux; unmapped addresses read zero
   always_comb
   begin
      next_rdata = 32'h0;
      unique case (haddr[7:0])
         `THC_REG_CTRL: next_rdata[3:0] = ctrl;
         `THC_REG_DISC:
         begin
            next_rdata[`THC_DISC1_LSB +: DW] = disc1_time;
            next_rdata[`THC_DISC2_LSB +: DW] = disc2_time;
         end
         `THC_REG_STAT:
         begin
            next_rdata[0] = en_int;
            next_rdata[1] = err1;
            next_rdata[2] = err2;
            next_rdata[3] = sync_fail;
            next_rdata[4] = run;
            next_rdata[11:8] = {p2_nc, p2_no, p1_nc, p1_no};
         end
         `THC_REG_IRQ_STAT: next_rdata[`THC_EV_W-1:0] = irq_stat;
         `THC_REG_IRQ_EN: next_rdata[`THC_EV_W-1:0] = irq_en;
         default: next_rdata = 32'h0;
      endcase
   end

   // read data registered at address phase, stands in data phase
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         hrdata <= 32'h0;
      else if (addr_ok && !hwrite)
         hrdata <= next_rdata;
   end

   ////////////////////////////////////////////////////////////////////
   // contact pairs
   logic p1_act;
   logic p2_act;
   logic p1_off;
   logic p2_off;
   logic err_any;
   logic err_clr;
   logic seq_clr;
   logic mode_clr;
   logic seen_off;
   logic run_q;

   assign p1_act = p1_no && !p1_nc;
   assign p2_act = p2_no && !p2_nc;
   assign p1_off = !p1_no && p1_nc;
   assign p2_off = !p2_no && p2_nc;
   assign err_any = err1 || err2;
   assign err_clr = seq_clr || mode_clr;

   thc_pair #(.DW(DW)) u_pair1 (
      .clk(ref_clk),
      .rst_n(rst_n),
      .scan(scan),
      .no_in(p1_no),
      .nc_in(p1_nc),
      .limit(disc1_time),
      .clr(err_clr),
      .err(err1)
   );

   thc_pair #(.DW(DW)) u_pair2 (
      .clk(ref_clk),
      .rst_n(rst_n),
      .scan(scan),
      .no_in(p2_no),
      .nc_in(p2_nc),
      .limit(disc2_time),
      .clr(err_clr),
      .err(err2)
   );

   // both released, then both pressed, clears errors
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         seen_off <= 1'b0;
         seq_clr <= 1'b0;
      end
      else
      begin
         seq_clr <= 1'b0;
         if (!err_any)
            seen_off <= 1'b0;
         else if (scan && p1_off && p2_off)
            seen_off <= 1'b1;
         else if (scan && seen_off && p1_act && p2_act)
         begin
            seen_off <= 1'b0;
            seq_clr <= 1'b1;
         end
      end
   end

   // return from idle to run clears errors
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run_q <= 1'b0;
         mode_clr <= 1'b0;
      end
      else
      begin
         run_q <= run;
         mode_clr <= run && !run_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // hand synchronisation
   thc_state_t state;
   logic [DW-1:0] sync_cnt;

   // start blocked: both hands must be released before a first press
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= THC_BLOCK;
         sync_cnt <= '0;
         sync_fail <= 1'b0;
      end
      else if (scan)
      begin
         unique case (state)
            THC_READY:
            begin
               sync_cnt <= '0;
               sync_fail <= 1'b0;
               if (err_any || !run)
                  state <= THC_BLOCK;
               else if (p1_act && p2_act)
                  state <= THC_ENABLE;
               // window opens on the first valid hand
               else if (p1_act || p2_act)
                  state <= THC_ARM;
            end
            THC_ARM:
            begin
               sync_cnt <= sync_cnt + 1'b1;
               if (err_any || !run)
                  state <= THC_BLOCK;
               else if (p1_act && p2_act)
                  state <= THC_ENABLE;
               // late hand: blocked, no error raised
               else if (sync_cnt >= DW'(SYNC_SCANS - 1))
               begin
                  state <= THC_BLOCK;
                  sync_fail <= 1'b1;
               end
               else if (!p1_act && !p2_act)
                  state <= THC_READY;
            end
            THC_ENABLE:
            begin
               // any release or error ends the cycle
               if (err_any || !run || !p1_act || !p2_act)
                  state <= THC_BLOCK;
            end
            THC_BLOCK:
            begin
               // new attempt only after both released
               if (p1_off && p2_off && !err_any && run)
                  state <= THC_READY;
            end
         endcase
      end
   end

   // enable needs pattern, state, run, no error
   assign en_int = (state == THC_ENABLE) && p1_act && p2_act && run && !err_any;

   ////////////////////////////////////////////////////////////////////
   // outputs and interrupt
   logic en_q;
   logic disc_err1_seen;
   logic disc_err2_seen;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_enable <= 1'b0;
         disc_err1 <= 1'b0;
         disc_err2 <= 1'b0;
         fault_present <= 1'b0;
         en_q <= 1'b0;
      end
      else
      begin
         out_enable <= en_int;
         en_q <= en_int;
         disc_err1 <= err1 && ctrl[`THC_CTRL_DISC1_OE];
         disc_err2 <= err2 && ctrl[`THC_CTRL_DISC2_OE];
         // fault only from discrepancy, when selected
         fault_present <= err_any && ctrl[`THC_CTRL_FAULT_OE];
      end
   end

   // event pulses for the sticky status
   always_comb
   begin
      events = '0;
      events[`THC_EV_DISC1] = err1 && !disc_err1_seen;
      events[`THC_EV_DISC2] = err2 && !disc_err2_seen;
      events[`THC_EV_SYNC] = scan && state == THC_ARM && sync_cnt >= DW'(SYNC_SCANS - 1)
         && !(p1_act && p2_act) && !err_any && run;
      events[`THC_EV_ENABLE] = en_int && !en_q;
   end

   // edge memory so each error raises its event once
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         disc_err1_seen <= 1'b0;
         disc_err2_seen <= 1'b0;
      end
      else
      begin
         disc_err1_seen <= err1;
         disc_err2_seen <= err2;
      end
   end

   // sticky bits; a new event outranks a same-cycle clear
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_stat <= '0;
      else
         irq_stat <= (irq_stat & ~irq_clr) | events;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |(irq_stat & irq_en);
   end

endmodule : thc_top
`default_nettype wire

// ---- bench/thc_top_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module thc_top_sva
(
   input wire logic ref_clk, // clock
   input wire logic rstn, // reset, low
   input wire logic hsel, // select
   input wire logic [31:0] haddr, // address
   input wire logic [1:0] htrans, // transfer
   input wire logic hwrite, // write
   input wire logic [31:0] hwdata, // wdata
   input wire logic hready, // ready
   input wire logic p1_no, // pair 1 open
   input wire logic p1_nc, // pair 1 closed
   input wire logic p2_no, // pair 2 open
   input wire logic p2_nc, // pair 2 closed
   input wire logic out_enable, // enable
   input wire logic disc_err1, // pair 1 error
   input wire logic disc_err2, // pair 2 error
   input wire logic fault_present // fault
);
   logic pend;
   logic [3:0] ctrl_q;
   logic both_act;
   ////////////////////////////////////////////////////////////////
   // shadow of the control word, so gating is judged from the bus
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pend <= 1'b0;
         ctrl_q <= 4'h0;
      end
      else if (hready)
      begin
         if (pend)
         begin
            ctrl_q <= hwdata[3:0];
         end
         pend <= hsel && htrans[1] && hwrite && (haddr[7:0] == 8'h00);
      end
   end
   // both pairs pressed
   assign both_act = p1_no && !p1_nc && p2_no && !p2_nc;
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   sequence s_run_back;
      $rose(ctrl_q[0]);
   endsequence
   sequence s_errs_gone;
      ##[1:3] (!disc_err1 && !disc_err2);
   endsequence
   chk_enable_pattern: assert property (out_enable |-> $past(both_act))
      else $error("enable without both pairs pressed");
   chk_error_blocks: assert property ((disc_err1 || disc_err2) |-> !out_enable)
      else $error("enable during error");
   chk_fault_safe: assert property (fault_present |-> !out_enable)
      else $error("enable during fault");
   chk_err1_gated: assert property (disc_err1 |-> ctrl_q[1] || $past(ctrl_q[1]))
      else $error("pair 1 error shown while off");
   chk_fault_gated: assert property (fault_present |-> ctrl_q[3] || $past(ctrl_q[3]))
      else $error("fault shown while off");
   // ctrl check at depth 2 skips a rise caused only by unmasking
   chk_err1_cause: assert property ($rose(disc_err1) && $past(ctrl_q[1], 2) |->
      $past(p1_no == p1_nc, 2)) else $error("pair 1 error without mismatch");
   chk_err2_cause: assert property ($rose(disc_err2) && $past(ctrl_q[2], 2) |->
      $past(p2_no == p2_nc, 2)) else $error("pair 2 error without mismatch");
   chk_run_clears: assert property (s_run_back |-> s_errs_gone)
      else $error("errors kept after run restart");
endmodule : thc_top_sva
bind thc_top thc_top_sva u_thc_top_sva
(
   .ref_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .p1_no, .p1_nc,
   .p2_no, .p2_nc, .out_enable, .disc_err1, .disc_err2, .fault_present
);
`default_nettype wire

// ---- bench/thc_hand_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module thc_hand_model
(
   input wire logic [1:0] mode1, // hand 1 state
   input wire logic [1:0] mode2, // hand 2 state
   output logic p1_no, // pair 1 open
   output logic p1_nc, // pair 1 closed
   output logic p2_no, // pair 2 open
   output logic p2_nc // pair 2 closed
);
   // 0 released, 1 pressed, 2 welded on, 3 broken off
   // operator release and press, and the welded and broken contact faults
   always_comb
   begin
      p1_no = (mode1 == 2'h1) || (mode1 == 2'h2);
      p1_nc = (mode1 == 2'h0) || (mode1 == 2'h2);
      p2_no = (mode2 == 2'h1) || (mode2 == 2'h2);
      p2_nc = (mode2 == 2'h0) || (mode2 == 2'h2);
   end
endmodule : thc_hand_model
`default_nettype wire

// ---- bench/two_hand_control_monitor_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module two_hand_control_monitor_test;
   localparam int SCAN = 4;
   localparam int SYNC = 5;
   logic ref_clk, rstn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, m1, m2;
   logic [2:0] hsize;
   logic p1_no, p1_nc, p2_no, p2_nc, out_enable, disc_err1, disc_err2, fault_present;
   int num_errors, samples_checked;
   ////////////////////////////////////////////////////////////////
   // short scan and window keep the run brief
   thc_top #(.SCAN_CYCLES(SCAN), .SYNC_SCANS(SYNC)) u_thc_top
   (
      .ref_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .p1_no, .p1_nc, .p2_no,
      .p2_nc, .out_enable, .disc_err1, .disc_err2, .fault_present, .irq
   );
   thc_hand_model u_thc_hand_model
   (
      .mode1(m1), .mode2(m2), .p1_no, .p1_nc, .p2_no, .p2_nc
   );
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // single word transfer; waits on ready, never on a fixed count
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      hwrite <= wr;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic hands(input logic [1:0] a, input logic [1:0] b, input int n);
      @(posedge ref_clk);
      m1 <= a;
      m2 <= b;
      repeat (n * SCAN) @(posedge ref_clk);
   endtask : hands
   task automatic t_regs;
      bus(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0303);
      bus(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      chk(hresp, 1'b0);
      bus(1'b1, 8'h04, 32'h3f3f);
      bus(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h3232);
      bus(1'b1, 8'h00, 32'hf);
      bus(1'b1, 8'h04, 32'h0);
   endtask : t_regs
   // zero limits: no pattern may ever flag
   task automatic t_truth;
      for (int i = 0; i < 16; i++)
      begin
         hands(2'h0, 2'h0, 2);
         hands(i[3:2], i[1:0], 3);
         @(negedge ref_clk);
         chk(out_enable, i == 5);
         chk({disc_err1, disc_err2, fault_present}, 3'h0);
      end
   endtask : t_truth
   task automatic t_disc;
      bus(1'b1, 8'h04, 32'h0302);
      hands(2'h0, 2'h0, 2);
      hands(2'h2, 2'h0, 0);
      repeat (2 * SCAN - 1) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(disc_err1, 1'b0);
      repeat (SCAN + 5) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({disc_err1, disc_err2}, 2'h2);
      chk({fault_present, out_enable}, 2'h2);
      hands(2'h0, 2'h0, 0);
      bus(1'b1, 8'h00, 32'h1);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({disc_err1, fault_present}, 2'h0);
      bus(1'b1, 8'h00, 32'hf);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(disc_err1, 1'b1);
      hands(2'h0, 2'h0, 2);
      hands(2'h1, 2'h1, 2);
      @(negedge ref_clk);
      chk({disc_err1, fault_present}, 2'h0);
   endtask : t_disc
   task automatic t_idle;
      hands(2'h0, 2'h2, 5);
      @(negedge ref_clk);
      chk({disc_err1, disc_err2}, 2'h1);
      hands(2'h0, 2'h0, 0);
      bus(1'b1, 8'h00, 32'he);
      bus(1'b1, 8'h00, 32'hf);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(disc_err2, 1'b0);
      hands(2'h0, 2'h0, 2);
      bus(1'b1, 8'h00, 32'he);
      hands(2'h1, 2'h1, 3);
      @(negedge ref_clk);
      chk(out_enable, 1'b0);
      bus(1'b1, 8'h00, 32'hf);
   endtask : t_idle
   task automatic t_sync;
      bus(1'b1, 8'h14, 32'hf);
      bus(1'b1, 8'h10, 32'h4);
      hands(2'h0, 2'h0, 2);
      hands(2'h1, 2'h0, SYNC + 2);
      hands(2'h1, 2'h1, 3);
      @(negedge ref_clk);
      chk({out_enable, disc_err1, disc_err2, fault_present, irq}, 5'h1);
      // status: sync fail and run set, both pairs pressed, no error
      bus(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h518);
      for (int i = 0; i < 3; i++)
      begin
         bus(1'b1, (i == 2) ? 8'h14 : 8'h10, (i == 0) ? 32'h0 : 32'h4);
         repeat (2) @(posedge ref_clk);
         @(negedge ref_clk);
         chk(irq, i == 1);
      end
      bus(1'b0, 8'h0c, 32'h0);
      chk(rd & 32'h4, 32'h0);
      hands(2'h0, 2'h0, 2);
      hands(2'h1, 2'h0, SYNC - 2);
      hands(2'h1, 2'h1, 2);
      @(negedge ref_clk);
      chk(out_enable, 1'b1);
      hands(2'h1, 2'h0, 1);
      @(negedge ref_clk);
      chk(out_enable, 1'b0);
   endtask : t_sync
   task automatic test_done;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
      begin
         $display("All tests passed");
      end
      else
      begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////
   // a hang ends the run through the normal verdict
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      test_done();
   end
   initial
   begin
      rstn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwdata = 32'h0;
      hsize = 3'h2;
      m1 = 2'h0;
      m2 = 2'h0;
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_regs();
      t_truth();
      t_disc();
      t_idle();
      t_sync();
      test_done();
   end
endmodule : two_hand_control_monitor_test
`default_nettype wire
